/* File: common/ctpg_cfg.svh */
// address map, reset values and fixed figures of the copper test packet block
`ifndef CTPG_CFG_SVH
`define CTPG_CFG_SVH

`define CTPG_ADDR_CTRL    8'h10
`define CTPG_ADDR_CNT     8'h14
`define CTPG_ADDR_CHK     8'h18
`define CTPG_ADDR_IPG     8'h1c
`define CTPG_ADDR_ISTAT   8'h20
`define CTPG_ADDR_IMASK   8'h24

`define CTPG_IDX_CTRL     3'd0
`define CTPG_IDX_CNT      3'd1
`define CTPG_IDX_CHK      3'd2
`define CTPG_IDX_IPG      3'd3
`define CTPG_IDX_ISTAT    3'd4
`define CTPG_IDX_IMASK    3'd5

`define CTPG_BIT_CNT_RST  4
`define CTPG_IRQ_DONE     0
`define CTPG_IRQ_RXERR    1
`define CTPG_IRQ_RXPKT    2

`define CTPG_RST_CTRL     16'h0000
`define CTPG_RST_IPG      8'h0b

`define CTPG_LEN_SHORT    11'h040
`define CTPG_LEN_LONG     11'h5ee
`define CTPG_FCS_BYTES    11'h004
`define CTPG_PAT_A        8'h5a
`define CTPG_PAT_B        8'ha5
`define CTPG_LFSR_SEED    16'hace1

`define CTPG_CRC_POLY     32'hedb88320
`define CTPG_CRC_INIT     32'hffffffff
`define CTPG_CRC_RESIDUE  32'hdebb20e3

`define CTPG_RESP_OKAY    2'b00
`define CTPG_RESP_SLVERR  2'b10

`endif

/* File: common/ctpg_pkg.sv */
// types shared by the copper test packet generator and checker
package ctpg_pkg;

    typedef struct packed {
        logic [7:0] burst;
        logic       trig;
        logic       sclr;
        logic       rsvd;
        logic       chk_en;
        logic       gen_en;
        logic       pat;
        logic       len;
        logic       err;
    } ctpg_ctrl_type;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [7:0] data;
    } ctpg_tx_type;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [7:0] data;
    } ctpg_rx_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DATA = 4'b0010,
        ST_FCS  = 4'b0100,
        ST_GAP  = 4'b1000
    } ctpg_state_type;

endpackage

/* File: rtl/ctpg_top.sv */
// copper port test packet generator, crc checker and register slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ctpg_cfg.svh"

module ctpg_top
    import ctpg_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output ctpg_tx_type      TX,
    input  wire ctpg_rx_type RX,
    output logic             PKT_GEN_MODE,
    output logic             IRQ
);

    // ***************************************************
    // helpers
    // ***************************************************
    function automatic logic [3:0] ctpg_decode(input logic [7:0] a);
        case (a)
            `CTPG_ADDR_CTRL:  ctpg_decode = {1'b1, `CTPG_IDX_CTRL};
            `CTPG_ADDR_CNT:   ctpg_decode = {1'b1, `CTPG_IDX_CNT};
            `CTPG_ADDR_CHK:   ctpg_decode = {1'b1, `CTPG_IDX_CHK};
            `CTPG_ADDR_IPG:   ctpg_decode = {1'b1, `CTPG_IDX_IPG};
            `CTPG_ADDR_ISTAT: ctpg_decode = {1'b1, `CTPG_IDX_ISTAT};
            `CTPG_ADDR_IMASK: ctpg_decode = {1'b1, `CTPG_IDX_IMASK};
            default:          ctpg_decode = 4'h0;
        endcase
    endfunction

    // reflected ethernet crc, one byte lsb first
    function automatic logic [31:0] ctpg_crc_byte(input logic [31:0] c,
                                                  input logic [7:0]  d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ `CTPG_CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        ctpg_crc_byte = r;
    endfunction

    // ***************************************************
    // declarations
    // ***************************************************
    logic           aw_held_reg;
    logic [7:0]     aw_addr_reg;
    logic           w_held_reg;
    logic [31:0]    w_data_reg;
    logic [3:0]     w_strb_reg;
    logic           bvalid_reg;
    logic [1:0]     bresp_reg;
    logic           rvalid_reg;
    logic [31:0]    rdata_reg;
    logic [1:0]     rresp_reg;

    ctpg_ctrl_type  ctrl_reg;
    ctpg_ctrl_type  ctrl_next;
    logic [7:0]     ipg_reg;
    logic [2:0]     istat_reg;
    logic [2:0]     imask_reg;

    ctpg_state_type state_reg;
    ctpg_state_type state_next;
    logic [10:0]    byte_cnt_reg;
    logic [10:0]    byte_cnt_next;
    logic [8:0]     gap_cnt_reg;
    logic [8:0]     gap_cnt_next;
    logic [7:0]     sent_cnt_reg;
    logic [31:0]    crc_reg;
    logic [31:0]    crc_next;
    logic [15:0]    lfsr_reg;
    logic [15:0]    lfsr_next;
    logic           run_reg;
    ctpg_tx_type    tx_reg;
    ctpg_tx_type    tx_next;

    logic           rx_dv_d_reg;
    logic [31:0]    rx_crc_reg;
    logic [7:0]     pkt_cnt_reg;
    logic [7:0]     err_cnt_reg;

    wire logic [3:0]   wr_dec;
    wire logic [3:0]   rd_dec;
    wire logic         do_write;
    wire logic         wr_lo;
    wire logic         wr_hi;
    wire logic         wr_ctrl;
    wire ctpg_ctrl_type wr_val;
    wire logic         gen_rise;
    wire logic         trig_wr;
    wire logic         start_burst;
    wire logic         burst_mode;
    wire logic         go;
    wire logic [10:0]  frame_last;
    wire logic [7:0]   pay_byte;
    wire logic [31:0]  fcs_word;
    wire logic [7:0]   fcs_byte;
    wire logic         pkt_done;
    wire logic         burst_end;
    wire logic [31:0]  rx_crc_seed;
    wire logic         rx_pkt_evt;
    wire logic         rx_err_evt;
    wire logic         cnt_clr;
    wire logic [2:0]   irq_set;
    wire logic [2:0]   irq_clr;
    wire logic [31:0]  rd_word;

    // ***************************************************
    // axi4-lite slave
    // ***************************************************
    // address and data are latched apart so either may come first
    assign S_AXI_AWREADY = ~aw_held_reg;
    assign S_AXI_WREADY  = ~w_held_reg;
    assign S_AXI_ARREADY = ~rvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;

    assign wr_dec   = ctpg_decode(aw_addr_reg);
    assign rd_dec   = ctpg_decode(S_AXI_ARADDR);
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_lo    = w_strb_reg[0];
    assign wr_hi    = w_strb_reg[1];
    assign wr_ctrl  = do_write & (wr_dec == {1'b1, `CTPG_IDX_CTRL});
    assign wr_val   = w_data_reg[15:0];

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `CTPG_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID && !w_held_reg) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_dec[3] ? `CTPG_RESP_OKAY : `CTPG_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign rd_word =
        (rd_dec[2:0] == `CTPG_IDX_CTRL)  ? {16'h0000, ctrl_reg} :
        (rd_dec[2:0] == `CTPG_IDX_CNT)   ? {16'h0000, pkt_cnt_reg,
                                            err_cnt_reg} :
        (rd_dec[2:0] == `CTPG_IDX_IPG)   ? {24'h000000, ipg_reg} :
        (rd_dec[2:0] == `CTPG_IDX_ISTAT) ? {29'h0, istat_reg} :
        (rd_dec[2:0] == `CTPG_IDX_IMASK) ? {29'h0, imask_reg} :
        32'h0000_0000; // counter reset reads 0

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `CTPG_RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_dec[3] ? rd_word : 32'h0000_0000;
            rresp_reg  <= rd_dec[3] ? `CTPG_RESP_OKAY : `CTPG_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ***************************************************
    // control register
    // ***************************************************
    assign burst_mode  = ctrl_reg.burst != 8'h00;
    assign gen_rise    = wr_ctrl & wr_lo & wr_val.gen_en & ~ctrl_reg.gen_en;
    // trig bit is status while it reads 0, so such writes fall through
    assign trig_wr     = wr_ctrl & wr_lo & ~wr_val.trig & ctrl_reg.trig &
                         ctrl_reg.sclr & ctrl_reg.gen_en & burst_mode;
    assign start_burst = gen_rise | trig_wr;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (start_burst) begin
            ctrl_next.trig = 1'b0;
        end else if (burst_end) begin
            ctrl_next.trig = 1'b1;
        end
        if (burst_end && !ctrl_reg.sclr) begin
            ctrl_next.gen_en = 1'b0;
        end
        if (wr_ctrl && wr_lo) begin
            ctrl_next.sclr   = wr_val.sclr;
            ctrl_next.chk_en = wr_val.chk_en;
            ctrl_next.gen_en = wr_val.gen_en;
            ctrl_next.pat    = wr_val.pat;
            ctrl_next.len    = wr_val.len;
            ctrl_next.err    = wr_val.err;
        end
        if (wr_ctrl && wr_hi) begin
            ctrl_next.burst = wr_val.burst;
        end
    end

    assign irq_set = {rx_pkt_evt, rx_err_evt, burst_end};
    assign irq_clr = (do_write && wr_lo &&
                      wr_dec == {1'b1, `CTPG_IDX_ISTAT}) ?
                     w_data_reg[2:0] : 3'b000;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_reg  <= `CTPG_RST_CTRL;
            ipg_reg   <= `CTPG_RST_IPG;
            istat_reg <= 3'b000;
            imask_reg <= 3'b000;
        end else begin
            ctrl_reg  <= ctrl_next;
            // a new event outranks a clear in the same cycle
            istat_reg <= (istat_reg & ~irq_clr) | irq_set;
            if (do_write && wr_lo && wr_dec == {1'b1, `CTPG_IDX_IPG}) begin
                ipg_reg <= w_data_reg[7:0];
            end
            if (do_write && wr_lo && wr_dec == {1'b1, `CTPG_IDX_IMASK}) begin
                imask_reg <= w_data_reg[2:0];
            end
        end
    end

    assign IRQ          = |(istat_reg & imask_reg);
    assign PKT_GEN_MODE = ctrl_reg.gen_en;

    // ***************************************************
    // packet generator
    // ***************************************************
    assign go         = run_reg & ctrl_reg.gen_en;
    assign frame_last = (ctrl_reg.len ? `CTPG_LEN_LONG : `CTPG_LEN_SHORT) -
                        `CTPG_FCS_BYTES - 11'h001;
    assign pay_byte   = ctrl_reg.pat ?
                        (byte_cnt_reg[0] ? `CTPG_PAT_B : `CTPG_PAT_A) :
                        lfsr_reg[7:0];
    assign fcs_word   = ~crc_reg ^ {32{ctrl_reg.err}};
    assign fcs_byte   = fcs_word[{byte_cnt_reg[1:0], 3'b000} +: 8];
    assign pkt_done   = (state_reg == ST_FCS) && (byte_cnt_reg[1:0] == 2'd3);
    assign burst_end  = pkt_done & run_reg & burst_mode &
                        (sent_cnt_reg == ctrl_reg.burst - 8'h01);

    always_comb begin
        state_next    = state_reg;
        byte_cnt_next = byte_cnt_reg;
        gap_cnt_next  = gap_cnt_reg;
        crc_next      = crc_reg;
        lfsr_next     = lfsr_reg;
        tx_next       = '0;
        unique case (state_reg)
            ST_IDLE: begin
                if (go) begin
                    state_next    = ST_DATA;
                    byte_cnt_next = 11'h000;
                    crc_next      = `CTPG_CRC_INIT;
                end
            end
            ST_DATA: begin
                tx_next       = {1'b1, 1'b0, pay_byte};
                crc_next      = ctpg_crc_byte(crc_reg, pay_byte);
                lfsr_next     = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                                 lfsr_reg[12] ^ lfsr_reg[10]};
                byte_cnt_next = byte_cnt_reg + 11'h001;
                if (byte_cnt_reg == frame_last) begin
                    state_next    = ST_FCS;
                    byte_cnt_next = 11'h000;
                end
            end
            ST_FCS: begin
                // symbol error rides on the last byte of a bad frame
                tx_next       = {1'b1, ctrl_reg.err & pkt_done, fcs_byte};
                byte_cnt_next = byte_cnt_reg + 11'h001;
                if (pkt_done) begin
                    if (burst_end || !ctrl_reg.gen_en) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next   = ST_GAP;
                        gap_cnt_next = {1'b0, ipg_reg};
                    end
                end
            end
            ST_GAP: begin
                gap_cnt_next = gap_cnt_reg - 9'h001;
                if (gap_cnt_reg == 9'h000) begin
                    state_next    = go ? ST_DATA : ST_IDLE;
                    byte_cnt_next = 11'h000;
                    crc_next      = `CTPG_CRC_INIT;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            state_reg    <= ST_IDLE;
            byte_cnt_reg <= 11'h000;
            gap_cnt_reg  <= 9'h000;
            crc_reg      <= `CTPG_CRC_INIT;
            lfsr_reg     <= `CTPG_LFSR_SEED;
            tx_reg       <= '0;
        end else begin
            state_reg    <= state_next;
            byte_cnt_reg <= byte_cnt_next;
            gap_cnt_reg  <= gap_cnt_next;
            crc_reg      <= crc_next;
            lfsr_reg     <= lfsr_next;
            tx_reg       <= tx_next;
        end
    end

    // a packet under way finishes after gen_en drops, so no runt leaves the port; only RESET cuts one short
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            run_reg      <= 1'b0;
            sent_cnt_reg <= 8'h00;
        end else begin
            if (start_burst) begin
                run_reg      <= 1'b1;
                sent_cnt_reg <= 8'h00;
            end else begin
                if (!ctrl_reg.gen_en || burst_end) begin
                    run_reg <= 1'b0;
                end
                if (pkt_done) begin
                    sent_cnt_reg <= sent_cnt_reg + 8'h01;
                end
            end
        end
    end

    assign TX = tx_reg;

    // ***************************************************
    // crc checker
    // ***************************************************
    assign rx_crc_seed = rx_dv_d_reg ? rx_crc_reg : `CTPG_CRC_INIT;
    assign rx_pkt_evt  = rx_dv_d_reg & ~RX.dv & ctrl_reg.chk_en;
    assign rx_err_evt  = rx_pkt_evt & (rx_crc_reg != `CTPG_CRC_RESIDUE);
    assign cnt_clr     = do_write & wr_lo &
                         (wr_dec == {1'b1, `CTPG_IDX_CHK}) &
                         w_data_reg[`CTPG_BIT_CNT_RST];

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rx_dv_d_reg <= 1'b0;
            rx_crc_reg  <= `CTPG_CRC_INIT;
            pkt_cnt_reg <= 8'h00;
            err_cnt_reg <= 8'h00;
        end else begin
            rx_dv_d_reg <= RX.dv;
            if (RX.dv) begin
                rx_crc_reg <= ctpg_crc_byte(rx_crc_seed, RX.data);
            end
            if (cnt_clr) begin
                pkt_cnt_reg <= 8'h00;
                err_cnt_reg <= 8'h00;
            end else begin
                if (rx_pkt_evt && pkt_cnt_reg != 8'hff) begin
                    pkt_cnt_reg <= pkt_cnt_reg + 8'h01;
                end
                if (rx_err_evt && err_cnt_reg != 8'hff) begin
                    err_cnt_reg <= err_cnt_reg + 8'h01;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: sim/ctpg_properties.sv */
// port checks for the copper test packet block
`timescale 1ns/1ps
`default_nettype none
module ctpg_properties
    import ctpg_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire ctpg_tx_type TX,
    input wire logic        PKT_GEN_MODE
);
    logic [10:0] run_reg;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // length of the transmit run, still held in the first idle cycle
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            run_reg <= 11'h000;
        end else begin
            run_reg <= TX.en ? run_reg + 11'h001 : 11'h000;
        end
    end
    frame_len_a: assert property ($fell(TX.en) |->
        run_reg == 11'h040 || run_reg == 11'h5ee)
        else $error("frame length wrong");
    sym_err_a: assert property (TX.er |-> TX.en ##1 !TX.en)
        else $error("symbol error off last byte");
    // a frame is launched one cycle before its first byte shows
    gen_mode_a: assert property ($rose(TX.en) |-> $past(PKT_GEN_MODE))
        else $error("frame outside generator mode");
    // the held pair is performed one cycle after it is taken
    write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
        S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    write_held_a: assert property (!S_AXI_AWREADY && !S_AXI_WREADY &&
        !S_AXI_BVALID |=> S_AXI_BVALID)
        else $error("held write not answered");
    write_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
        !S_AXI_BVALID)
        else $error("write response repeated");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID)
        else $error("read data late");
    read_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken during data");
    read_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=>
        !S_AXI_RVALID)
        else $error("read data repeated");
    cover property ($fell(TX.en) && run_reg == 11'h5ee);
    cover property (TX.er);
    cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule
`default_nettype wire

/* File: sim/ctpg_link_model.sv */
// loopback model of the copper datapath behind the generator
`timescale 1ns/1ps
`default_nettype none
module ctpg_link_model
    import ctpg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        link_up,
    input  wire ctpg_tx_type tx,
    output var ctpg_rx_type  rx
);
    initial rx = '0;
    // idle receive bytes toggle so a stale byte never looks valid
    always @(posedge clk) begin
        if (link_up && tx.en) begin
            rx <= {1'b1, tx.er, tx.data};
        end else begin
            rx <= {2'h0, ~rx.data};
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the copper test packet block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ctpg_pkg::*;
;
    logic        CORE_CLK = 1'b0, RESET = 1'b1;
    logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB = 4'h0;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rs;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic        S_AXI_ARVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic        S_AXI_RREADY = 1'b0, link_up = 1'b1, er_seen = 1'b0;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic        S_AXI_ARREADY, S_AXI_RVALID, PKT_GEN_MODE, IRQ;
    ctpg_tx_type TX;
    ctpg_rx_type RX;
    logic [7:0]  b0, b1;
    logic [31:0] rd;
    int          errors = 0, check_count = 0, cycles = 0, n;
    int          frames = 0, flen = 0, gap = 0, run = 0, idle = 0;
    logic [7:0]  row_addr [7] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
                                  8'h24, 8'h30};
    logic [15:0] row_data [7] = '{16'h0, 16'h0, 16'h0, 16'h000b, 16'h0,
                                  16'h0, 16'h0};
    logic [1:0]  row_resp [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
                                  2'h2};

    ctpg_top i_ctpg_top (.*);
    ctpg_link_model i_ctpg_link_model (.clk(CORE_CLK), .link_up(link_up),
                                       .tx(TX), .rx(RX));

    always #12.5 CORE_CLK = ~CORE_CLK;

    // ****************************************
    // frame monitor and timeout
    // ****************************************
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
        if (TX.en === 1'b1) begin
            gap = (run == 0) ? idle : gap;
            b0 = (run == 0) ? TX.data : b0;
            b1 = (run == 1) ? TX.data : b1;
            er_seen = er_seen | TX.er;
            run++;
            idle = 0;
        end else begin
            frames = (run > 0) ? frames + 1 : frames;
            flen = (run > 0) ? run : flen;
            run = 0;
            idle++;
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        rs = S_AXI_BRESP;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge CORE_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        rd = S_AXI_RDATA;
        rs = S_AXI_RRESP;
    endtask

    task automatic wait_done();
        do begin
            rd_reg(8'h10);
        end while (rd[7] !== 1'b1);
        // let the frame monitor close the last frame first
        @(posedge CORE_CLK);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd_reg(row_addr[i]);
            check("reset data", {16'h0, row_data[i]}, rd);
            check("read resp", {30'h0, row_resp[i]}, {30'h0, rs});
        end
        $display("test table done");
        wr(8'h1c, 32'h3, 4'h1);
        wr(8'h1c, 32'hf00, 4'h2);
        wr(8'h30, 32'hffff, 4'h3);
        check("unmapped write resp", 32'h2, {30'h0, rs});
        wr(8'h10, 32'h021c, 4'h3);
        wait_done();
        check("status after burst", 32'h0294, rd);
        check("frames in burst", 32'h2, 32'(frames));
        check("frame length", 32'h40, 32'(flen));
        check("gap", 32'h4, 32'(gap));
        check("pattern", 32'h5aa5, {16'h0, b0, b1});
        check("gen mode", 32'h0, {31'h0, PKT_GEN_MODE});
        rd_reg(8'h14);
        check("counters", 32'h0200, rd);
        rd_reg(8'h20);
        check("irq status", 32'h5, rd);
        check("irq masked", 32'h0, {31'h0, IRQ});
        wr(8'h24, 32'h1, 4'h1);
        check("irq raised", 32'h1, {31'h0, IRQ});
        wr(8'h20, 32'h1, 4'h1);
        check("irq cleared", 32'h0, {31'h0, IRQ});
        $display("test burst done");
        wr(8'h10, 32'h0148, 4'h3);
        wait_done();
        check("enable kept", 32'h01c8, rd);
        check("random payload", 32'h1, {31'h0, {b0, b1} != 16'h5aa5});
        n = frames;
        wr(8'h10, 32'h0148, 4'h3);
        wr(8'h10, 32'h01c8, 4'h3);
        rd_reg(8'h10);
        check("status running", 32'h0148, rd);
        wr(8'h10, 32'h0148, 4'h3);
        wait_done();
        check("retrigger frames", 32'h1, 32'(frames - n));
        rd_reg(8'h14);
        check("checker off", 32'h0200, rd);
        $display("test trigger done");
        wr(8'h18, 32'h10, 4'h1);
        rd_reg(8'h14);
        check("counters cleared", 32'h0, rd);
        rd_reg(8'h18);
        check("clear reads 0", 32'h0, rd);
        wr(8'h10, 32'h0080, 4'h3);
        er_seen = 1'b0;
        wr(8'h10, 32'h0119, 4'h3);
        wait_done();
        rd_reg(8'h14);
        check("error counts", 32'h0101, rd);
        check("symbol error", 32'h1, {31'h0, er_seen});
        $display("test error done");
        link_up <= 1'b0;
        wr(8'h10, 32'h000a, 4'h3);
        n = frames;
        wait (frames >= n + 2);
        check("mode kept", 32'h1, {31'h0, PKT_GEN_MODE});
        check("long frame", 32'h5ee, 32'(flen));
        wr(8'h10, 32'h0, 4'h3);
        // one long frame may still finish after the enable drops
        repeat (1600) @(posedge CORE_CLK);
        n = frames;
        repeat (1600) @(posedge CORE_CLK);
        check("stopped", 32'h0, 32'(frames - n));
        check("normal mode", 32'h0, {31'h0, PKT_GEN_MODE});
        $display("test continuous done");
        wr(8'h10, 32'h000a, 4'h3);
        repeat (20) @(posedge CORE_CLK);
        RESET <= 1'b1;
        @(posedge CORE_CLK);
        check("tx in reset", 32'h0, {22'h0, TX});
        @(posedge CORE_CLK);
        RESET <= 1'b0;
        rd_reg(8'h10);
        check("control after reset", 32'h0, rd);
        $display("test reset done");
        complete_run();
    end
endmodule

bind ctpg_top ctpg_properties i_ctpg_properties (.*);
`default_nettype wire
